/* File: rudc_counter.sv */
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "rudc_regs.svh"
module rudc_counter (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, active high
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic wb_we_i, // write enable
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  output logic wb_ack_o, // acknowledge
  input wire logic cnt_up_i, // up count pulse
  input wire logic cnt_down_i, // down count pulse
  output logic [31:0] count_o, // counter value
  output logic below_o, // wrap-below flag
  output logic above_o, // wrap-above flag
  output logic irq_o // interrupt level
);
  rudc_pkg::rudc_unsigned_32bit_word_t count_r, preset_r, limit_r, rdat_r;
  logic reload_en_r;
  logic below_r, above_r;
  logic [`RUDC_ST_W-1:0] stat_r, mask_r;
  logic ack_r;
  logic load_req;
  logic wr_ok;
  rudc_step_if st ();

  // byte-lane merge helper
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // bus write strobe, one per access
  assign wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  assign load_req = wr_ok && hit(wb_adr_i, `RUDC_CTRL_OFS) && wb_sel_i[0]
                    && wb_dat_i[`RUDC_CTRL_LOAD];

  // step operands
  assign st.count = count_r;
  assign st.limit = limit_r;
  assign st.reload_en = reload_en_r;
  assign st.preset = preset_r;
  always_comb begin
    if (load_req) begin
      st.op = rudc_pkg::RUDC_LOAD;
    end else if (cnt_up_i && !cnt_down_i) begin
      st.op = rudc_pkg::RUDC_UP;
    end else if (cnt_down_i && !cnt_up_i) begin
      st.op = rudc_pkg::RUDC_DOWN;
    end else begin
      st.op = rudc_pkg::RUDC_HOLD;
    end
  end

  rudc_step u_step (
    .s(st)
  );

  // counter register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= `RUDC_RST_VAL;
    end else begin
      count_r <= st.next;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preset_r <= `RUDC_RST_VAL;
      limit_r <= `RUDC_RST_VAL;
      reload_en_r <= 1'b0;
      mask_r <= '0;
    end else if (wr_ok) begin
      if (hit(wb_adr_i, `RUDC_PRESET_OFS)) begin
        preset_r <= merge(preset_r, wb_dat_i, wb_sel_i);
      end
      if (hit(wb_adr_i, `RUDC_LIMIT_OFS)) begin
        limit_r <= merge(limit_r, wb_dat_i, wb_sel_i);
      end
      if (hit(wb_adr_i, `RUDC_CTRL_OFS) && wb_sel_i[0]) begin
        reload_en_r <= wb_dat_i[`RUDC_CTRL_RELOAD_EN];
      end
      if (hit(wb_adr_i, `RUDC_MASK_OFS) && wb_sel_i[0]) begin
        mask_r <= wb_dat_i[`RUDC_ST_W-1:0];
      end
    end
  end

  // wrap flags with hysteresis clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      below_r <= 1'b0;
      above_r <= 1'b0;
    end else begin
      if (st.wrap_below) begin
        below_r <= 1'b1;
      end else if (above_r && !below_r) begin
        below_r <= below_r;
      end else if ((st.op == rudc_pkg::RUDC_UP && st.next == `RUDC_CLR_UP) ||
                   (st.op == rudc_pkg::RUDC_DOWN && st.next == `RUDC_CLR_DN) ||
                   st.wrap_above) begin
        below_r <= 1'b0;
      end
      if (st.wrap_above) begin
        above_r <= 1'b1;
      end else if ((st.op == rudc_pkg::RUDC_UP && st.next == `RUDC_CLR_UP) ||
                   (st.op == rudc_pkg::RUDC_DOWN && st.next == `RUDC_CLR_DN) ||
                   st.wrap_below) begin
        above_r <= 1'b0;
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= '0;
    end else begin
      logic [`RUDC_ST_W-1:0] clr;
      logic [`RUDC_ST_W-1:0] set;
      clr = (wr_ok && hit(wb_adr_i, `RUDC_STAT_OFS) && wb_sel_i[0]) ?
            wb_dat_i[`RUDC_ST_W-1:0] : '0;
      set = {load_req, st.wrap_above, st.wrap_below};
      stat_r <= (stat_r & ~clr) | set;
    end
  end

  // read mux, registered, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= '0;
    end else begin
      case (wb_adr_i)
        `RUDC_CTRL_OFS: rdat_r <= {31'h0, reload_en_r};
        `RUDC_PRESET_OFS: rdat_r <= preset_r;
        `RUDC_LIMIT_OFS: rdat_r <= limit_r;
        `RUDC_COUNT_OFS: rdat_r <= count_r;
        `RUDC_STAT_OFS: rdat_r <= {29'h0, stat_r};
        `RUDC_MASK_OFS: rdat_r <= {29'h0, mask_r};
        default: rdat_r <= '0;
      endcase
    end
  end

  // ack one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign count_o = count_r;
  assign below_o = below_r;
  assign above_o = above_r;
  assign irq_o = |(stat_r & mask_r);
endmodule // rudc_counter

/* File: rudc_counter_asserts.sv */
`timescale 1ns/1ps
`include "rudc_regs.svh"
// port checks for the counter
module rudc_counter_asserts (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic wb_ack_o, // ack
  input wire logic cnt_up_i, // up pulse
  input wire logic cnt_down_i, // down pulse
  input wire logic [31:0] count_o, // count
  input wire logic below_o, // below flag
  input wire logic above_o // above flag
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // taken write and lone steps
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire up = cnt_up_i & ~cnt_down_i & ~wr;
  wire dn = cnt_down_i & ~cnt_up_i & ~wr;
  a_ack_next: assert property (wb_cyc_i & wb_stb_i & ~wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_idle_hold: assert property ((!wr || wb_adr_i == `RUDC_PRESET_OFS) &&
    cnt_up_i == cnt_down_i |=> $stable(count_o)) else $error("count moved");
  a_step_up: assert property (up && count_o != `RUDC_MAX_CNT |=>
    count_o == $past(count_o) + 32'h1 || count_o == 32'h0) else $error("bad up");
  a_step_down: assert property (dn && count_o != 32'h0 |=>
    count_o == $past(count_o) - 32'h1) else $error("bad down");
  a_top_wrap: assert property (up && count_o == `RUDC_MAX_CNT |=> count_o == 32'h0)
    else $error("no top wrap");
  a_below_set: assert property ($rose(below_o) |-> $past(count_o) == 32'h0 &&
    count_o == `RUDC_MAX_CNT && !above_o) else $error("bad below");
  a_above_set: assert property ($rose(above_o) |-> count_o == 32'h0 &&
    $past(count_o) == `RUDC_MAX_CNT && !below_o) else $error("bad above");
  a_clr_up: assert property (up && count_o == 32'h3fff |=> !below_o && !above_o)
    else $error("flags kept up");
  a_clr_down: assert property (dn && count_o == 32'hffffc001 |=> !below_o && !above_o)
    else $error("flags kept down");
endmodule // rudc_counter_asserts
bind rudc_counter rudc_counter_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_ack_o, .cnt_up_i, .cnt_down_i, .count_o, .below_o, .above_o);

/* File: rudc_counter_tb.sv */
`timescale 1ns/1ps
`include "rudc_regs.svh"
module rudc_counter_tb;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, cnt_up_i, cnt_down_i;
  logic below_o, above_o, irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, count_o, rd;
  wire [31:0] flags = {30'h0, above_o, below_o};
  int error_cnt = 0;
  int checks = 0;
  rudc_counter DUT (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cnt_up_i, .cnt_down_i, .count_o, .below_o, .above_o,
    .irq_o);
  rudc_pulse_src src (.clk_i, .up_o(cnt_up_i), .down_o(cnt_down_i));
  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one classic bus cycle, read data lands in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // wait for ack as long as it takes, the hang guard ends a lost cycle
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic load(input logic [31:0] v, input logic r);
    bus(`RUDC_PRESET_OFS, 1'b1, v);
    bus(`RUDC_CTRL_OFS, 1'b1, {30'h0, 1'b1, r});
  endtask
  task automatic t_preset();
    bus(`RUDC_PRESET_OFS, 1'b1, 32'h55);
    chk(count_o, 32'h0);
    bus(`RUDC_CTRL_OFS, 1'b1, 32'h2);
    chk(count_o, 32'h55);
    bus(`RUDC_STAT_OFS, 1'b0, 32'h0);
    chk(rd, 32'h4);
    bus(`RUDC_COUNT_OFS, 1'b0, 32'h0);
    chk(rd, 32'h55);
    bus(8'h3c, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_wraps();
    load(32'h1, 1'b0);
    bus(`RUDC_MASK_OFS, 1'b1, 32'h1);
    bus(`RUDC_MASK_OFS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    src.pulse(1'b0, 2);
    chk(count_o, `RUDC_MAX_CNT);
    chk(flags, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    bus(`RUDC_STAT_OFS, 1'b1, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    src.pulse(1'b1, 1);
    chk(count_o, 32'h0);
    chk(flags, 32'h2);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic t_hyst();
    load(32'h3ffe, 1'b0);
    src.pulse(1'b1, 1);
    chk(flags, 32'h2);
    src.pulse(1'b1, 1);
    chk(flags, 32'h0);
    load(32'h0, 1'b0);
    src.pulse(1'b0, 1);
    load(32'hffffc002, 1'b0);
    src.pulse(1'b0, 2);
    chk(count_o, 32'hffffc000);
    chk(flags, 32'h0);
  endtask
  task automatic t_reload();
    bus(`RUDC_LIMIT_OFS, 1'b1, 32'h5);
    load(32'h3, 1'b1);
    bus(`RUDC_CTRL_OFS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    bus(`RUDC_LIMIT_OFS, 1'b0, 32'h0);
    chk(rd, 32'h5);
    src.pulse(1'b1, 2);
    chk(count_o, 32'h5);
    src.pulse(1'b1, 1);
    chk(count_o, 32'h0);
    src.pulse(1'b0, 1);
    chk(count_o, 32'h5);
    load(32'h5, 1'b0);
    src.pulse(1'b1, 1);
    chk(count_o, 32'h6);
    src.both();
    chk(count_o, 32'h6);
  endtask
  // reset, then the scenarios
  initial begin
    rst_i = 1'b1;
    {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(count_o, 32'h0);
    t_preset();
    t_wraps();
    t_hyst();
    t_reload();
    stop_test();
  end
  // hang guard
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule // rudc_counter_tb

/* File: rudc_pkg.sv */
package rudc_pkg;
  typedef logic [31:0] rudc_unsigned_32bit_word_t;
  typedef enum logic [1:0] {
    RUDC_HOLD = 2'b00,
    RUDC_UP = 2'b01,
    RUDC_DOWN = 2'b11,
    RUDC_LOAD = 2'b10
  } rudc_op_t;
endpackage

/* File: rudc_pulse_src.sv */
`timescale 1ns/1ps
// counting input source, one step per clock
module rudc_pulse_src (
  input wire logic clk_i, // clock
  output logic up_o, // up pulse
  output logic down_o // down pulse
);
  // quiet at start
  initial begin
    up_o = 1'b0;
    down_o = 1'b0;
  end
  // n back-to-back steps, dir 1 is up
  task automatic pulse(input logic dir, input int n);
    repeat (n) begin
      up_o <= dir;
      down_o <= !dir;
      @(posedge clk_i);
    end
    up_o <= 1'b0;
    down_o <= 1'b0;
    @(posedge clk_i);
  endtask
  // both lines high for one cycle, which means no step
  task automatic both();
    up_o <= 1'b1;
    down_o <= 1'b1;
    @(posedge clk_i);
    up_o <= 1'b0;
    down_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule // rudc_pulse_src

/* File: rudc_regs.svh */
`ifndef RUDC_REGS_SVH
`define RUDC_REGS_SVH
// register byte offsets
`define RUDC_CTRL_OFS 8'h00
`define RUDC_PRESET_OFS 8'h04
`define RUDC_LIMIT_OFS 8'h08
`define RUDC_COUNT_OFS 8'h0c
`define RUDC_STAT_OFS 8'h10
`define RUDC_MASK_OFS 8'h14
// control fields
`define RUDC_CTRL_RELOAD_EN 0
`define RUDC_CTRL_LOAD 1
// status fields
`define RUDC_ST_BELOW 0
`define RUDC_ST_ABOVE 1
`define RUDC_ST_LOADED 2
`define RUDC_ST_W 3
// counter constants
`define RUDC_MAX_CNT 32'hffffffff
`define RUDC_CLR_UP 32'h00004000
`define RUDC_CLR_DN 32'hffffc000
`define RUDC_RST_VAL 32'h00000000
`endif

/* File: rudc_step.sv */
`timescale 1ns/1ps
`include "rudc_regs.svh"
// next-count arithmetic
module rudc_step (
  rudc_step_if.core s // step operands and result
);
  always_comb begin
    s.next = s.count;
    s.wrap_below = 1'b0;
    s.wrap_above = 1'b0;
    case (s.op)
      rudc_pkg::RUDC_LOAD: s.next = s.preset;
      rudc_pkg::RUDC_UP: begin
        if (s.reload_en && s.count == s.limit) begin
          s.next = `RUDC_RST_VAL;
        end else if (s.count == `RUDC_MAX_CNT) begin
          s.next = `RUDC_RST_VAL;
          s.wrap_above = 1'b1;
        end else begin
          s.next = s.count + 32'h00000001;
        end
      end
      rudc_pkg::RUDC_DOWN: begin
        if (s.reload_en && s.count == `RUDC_RST_VAL) begin
          s.next = s.limit;
        end else if (s.count == `RUDC_RST_VAL) begin
          s.next = `RUDC_MAX_CNT;
          s.wrap_below = 1'b1;
        end else begin
          s.next = s.count - 32'h00000001;
        end
      end
      default: s.next = s.count;
    endcase
  end
endmodule // rudc_step

/* File: rudc_step_if.sv */
`timescale 1ns/1ps
interface rudc_step_if;
  logic [31:0] count;
  logic [31:0] limit;
  logic reload_en;
  rudc_pkg::rudc_op_t op;
  logic [31:0] preset;
  logic [31:0] next;
  logic wrap_below;
  logic wrap_above;
  modport core (input count, limit, reload_en, op, preset,
                output next, wrap_below, wrap_above);
  modport user (output count, limit, reload_en, op, preset,
                input next, wrap_below, wrap_above);
endinterface
